//--- logic/pll_ctrl_map.vh
// Field layout, reset values and timing constants of the PLL control block
// Assumes inclusion by bare name from the logic folder
`ifndef PLL_CTRL_MAP_VH
`define PLL_CTRL_MAP_VH

// Serial word layout
`define WORD_W         19
`define SEL_BIT        0
`define SEL_N          1'b0
`define SEL_R          1'b1
`define N_LSB          1
`define N_W            18
`define N_NARROW_W     16
`define SWALLOW_W      5
`define MAIN_W         13
`define PRESCALE_LAST  6'h1F
`define PRESCALE_XLAST 6'h20
`define RD_LSB         4
`define RD_W           15
`define RD_NARROW_W    13
`define LOCK_EN_BIT    3
`define REF_BYPASS_BIT 2
`define TEST_BIT       1
`define REF_PRE_LAST   3'h7

// Reset values, phase error counter width and limit
`define WORD_RST       19'h00000
`define N_RST          18'h00000
`define RD_RST         15'h0000
`define ERR_W          16
`define ERR_MAX        16'hFFFF

// Lock window
`define CLK_PERIOD_NS  50
`define LOCK_TOL_NS    100
`define LOCK_TOL_CYC   (`LOCK_TOL_NS / `CLK_PERIOD_NS)

`endif

//--- logic/pll_divider_programming.v
// Digital control of a PLL synthesizer: serial load, dividers, phase and lock detect
// Assumes all inputs are asynchronous pins sampled by the 20 MHz sys_clk_in
`timescale 1ns/10ps
`include "pll_ctrl_map.vh"

// Notes on behaviour
// RULE1 - N word: bits 18..1 value, bit 0 selector
// RULE2 - Selector 0 loads the feedback divider latch
// RULE3 - Selector 1 loads the reference divider latch
// RULE4 - Width select high uses low 16 bits
// RULE5 - Swallow, dual-modulus prescaler and main counter
// RULE6 - Division equals 32 times main plus swallow
// RULE7 - Width select low extends range to 262143
// RULE8 - Lock enable zero holds lock output low
// RULE9 - Bypass zero: divide by 8, 13-bit counter
// RULE10 - Bypass one: 15-bit counter used directly
// RULE11 - Test pin and bit choose test outputs
// RULE12 - Phase detector pulses for the phase difference
// RULE13 - Lock output low during phase error
// RULE14 - Fast lock fires once after start-up
// RULE15 - Fast-lock control raises charge pump current
// RULE16 - Battery save stops dividers, keeps latches
// RULE17 - Serial shift, load on enable rise
// RULE18 - Unprogrammed and lock disabled until both loaded
module pll_divider_programming #(
  parameter WORD_W       = `WORD_W,
  parameter LOCK_TOL_CYC = `LOCK_TOL_CYC
) (
  // Clock and reset
  input  wire sys_clk_in,
  input  wire nrst_in,
  // Serial load from the host
  input  wire ser_data_in,
  input  wire ser_clk_in,
  input  wire ser_en_in,
  // Control pins
  input  wire divider_width_select_in,
  input  wire test_pin_in,
  input  wire fast_lock_control_in,
  input  wire battery_save_n_in,
  // Divider inputs
  input  wire fin_in,
  input  wire ref_in,
  // Outputs
  output reg  lock_detect_out,
  output reg  fast_lock_out,
  output reg  charge_pump_up_out,
  output reg  charge_pump_dn_out,
  output reg  charge_pump_boost_out
);

  localparam NSYNC  = 9;
  localparam I_DATA = 0;
  localparam I_SCLK = 1;
  localparam I_EN   = 2;
  localparam I_WSEL = 3;
  localparam I_TEST = 4;
  localparam I_FLC  = 5;
  localparam I_BSN  = 6;
  localparam I_FIN  = 7;
  localparam I_REF  = 8;

  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] meta_r;
  reg  [NSYNC-1:0] sync_r;
  reg  [NSYNC-1:0] prev_r;

  assign raw_in = {ref_in, fin_in, battery_save_n_in, fast_lock_control_in,
                   test_pin_in, divider_width_select_in, ser_en_in,
                   ser_clk_in, ser_data_in};

  // Two-stage synchronisers plus an edge history stage
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge sys_clk_in)
      begin
        if (!nrst_in)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= raw_in[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  wire sclk_rise = sync_r[I_SCLK] & ~prev_r[I_SCLK];
  wire en_rise   = sync_r[I_EN] & ~prev_r[I_EN];
  wire fin_rise  = sync_r[I_FIN] & ~prev_r[I_FIN];
  wire ref_rise  = sync_r[I_REF] & ~prev_r[I_REF];
  wire wsel      = sync_r[I_WSEL];
  wire tpin      = sync_r[I_TEST];
  wire powered   = sync_r[I_BSN];

  // Serial shift register and latches
  reg [WORD_W-1:0]      shift_r;
  reg [`N_W-1:0]        n_word_r;
  reg                   n_ok_r;
  reg [`RD_W-1:0]       rd_r;
  reg                   lock_en_r;
  reg                   bypass_r;
  reg                   test_bit_r;
  reg                   r_ok_r;

  // Latches are not touched by battery save
  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      shift_r    <= `WORD_RST;
      n_word_r   <= `N_RST;
      n_ok_r     <= 1'b0; // RULE18
      rd_r       <= `RD_RST;
      lock_en_r  <= 1'b0; // RULE18
      bypass_r   <= 1'b0;
      test_bit_r <= 1'b0;
      r_ok_r     <= 1'b0; // RULE18
    end
    else
    begin
      if (sclk_rise)
        shift_r <= {shift_r[WORD_W-2:0], sync_r[I_DATA]}; // RULE17
      if (en_rise)
      begin
        if (shift_r[`SEL_BIT] == `SEL_N) // RULE1
        begin
          n_word_r <= shift_r[`N_LSB +: `N_W]; // RULE2
          n_ok_r   <= 1'b1;
        end
        else
        begin
          rd_r       <= shift_r[`RD_LSB +: `RD_W]; // RULE3
          lock_en_r  <= shift_r[`LOCK_EN_BIT];
          bypass_r   <= shift_r[`REF_BYPASS_BIT];
          test_bit_r <= shift_r[`TEST_BIT];
          r_ok_r     <= 1'b1;
        end
      end
    end
  end

  // Effective N value by width select
  wire [`N_W-1:0] n_val = wsel ?
    {{(`N_W-`N_NARROW_W){1'b0}}, n_word_r[`N_NARROW_W-1:0]} : // RULE4
    n_word_r; // RULE7
  wire [`SWALLOW_W-1:0] swallow_val = n_val[`SWALLOW_W-1:0];
  wire [`MAIN_W-1:0]    main_val    = n_val[`N_W-1:`SWALLOW_W]; // RULE5

  wire run = n_ok_r & r_ok_r & powered; // RULE16

  // Feedback divider: prescaler, swallow and main counters
  reg [5:0]            pre_cnt_r;
  reg [`SWALLOW_W-1:0] sw_cnt_r;
  reg [`MAIN_W-1:0]    main_cnt_r;
  reg                  fn_p_r;
  reg                  fn_tgl_r;
  wire [5:0]           pre_last = (sw_cnt_r != {`SWALLOW_W{1'b0}}) ?
                                  `PRESCALE_XLAST : `PRESCALE_LAST; // RULE6

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      pre_cnt_r  <= 6'h00;
      sw_cnt_r   <= {`SWALLOW_W{1'b0}};
      main_cnt_r <= {`MAIN_W{1'b0}};
      fn_p_r     <= 1'b0;
      fn_tgl_r   <= 1'b0;
    end
    else if (!run)
    begin
      pre_cnt_r  <= 6'h00;
      sw_cnt_r   <= swallow_val;
      main_cnt_r <= main_val;
      fn_p_r     <= 1'b0;
    end
    else
    begin
      fn_p_r <= 1'b0;
      if (fin_rise)
      begin
        if (pre_cnt_r == pre_last) // RULE5
        begin
          pre_cnt_r <= 6'h00;
          if (main_cnt_r <= {{(`MAIN_W-1){1'b0}}, 1'b1})
          begin
            main_cnt_r <= main_val; // RULE6
            sw_cnt_r   <= swallow_val;
            fn_p_r     <= 1'b1;
            fn_tgl_r   <= ~fn_tgl_r;
          end
          else
          begin
            main_cnt_r <= main_cnt_r - {{(`MAIN_W-1){1'b0}}, 1'b1};
            if (sw_cnt_r != {`SWALLOW_W{1'b0}})
              sw_cnt_r <= sw_cnt_r - {{(`SWALLOW_W-1){1'b0}}, 1'b1};
          end
        end
        else
          pre_cnt_r <= pre_cnt_r + 6'h01;
      end
    end
  end

  // Reference divider: optional divide by 8 then programmable counter
  reg  [2:0]       ref_pre_r;
  reg  [`RD_W-1:0] r_cnt_r;
  reg              fr_p_r;
  reg              fr_tgl_r;
  wire [`RD_W-1:0] rd_term = bypass_r ? rd_r : // RULE10
    {{(`RD_W-`RD_NARROW_W){1'b0}}, rd_r[`RD_NARROW_W-1:0]}; // RULE9
  wire ref_tick = ref_rise & (bypass_r | (ref_pre_r == `REF_PRE_LAST)); // RULE9

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      ref_pre_r <= 3'h0;
      r_cnt_r   <= `RD_RST;
      fr_p_r    <= 1'b0;
      fr_tgl_r  <= 1'b0;
    end
    else if (!run)
    begin
      ref_pre_r <= 3'h0;
      r_cnt_r   <= `RD_RST;
      fr_p_r    <= 1'b0;
    end
    else
    begin
      fr_p_r <= 1'b0;
      if (ref_rise)
        ref_pre_r <= ref_pre_r + 3'h1;
      if (ref_tick)
      begin
        if (r_cnt_r >= rd_term - {{(`RD_W-1){1'b0}}, 1'b1})
        begin
          r_cnt_r  <= `RD_RST;
          fr_p_r   <= 1'b1;
          fr_tgl_r <= ~fr_tgl_r;
        end
        else
          r_cnt_r <= r_cnt_r + {{(`RD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Phase frequency detector
  reg              up_r;
  reg              dn_r;
  reg [`ERR_W-1:0] err_w_r;
  reg              fl_on_r;
  reg              fl_done_r;
  wire up_set  = up_r | fr_p_r;
  wire dn_set  = dn_r | fn_p_r;
  wire pd_both = up_set & dn_set;
  wire pd_act  = up_r | dn_r;
  wire pd_nxt  = (up_set | dn_set) & ~pd_both;
  wire cmp_done = (pd_act & ~pd_nxt) | (fn_p_r & fr_p_r & ~pd_act);
  wire locked_evt = cmp_done & (err_w_r <= LOCK_TOL_CYC[`ERR_W-1:0]);

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      up_r    <= 1'b0;
      dn_r    <= 1'b0;
      err_w_r <= {`ERR_W{1'b0}};
    end
    else if (!run)
    begin
      up_r    <= 1'b0;
      dn_r    <= 1'b0;
      err_w_r <= {`ERR_W{1'b0}};
    end
    else
    begin
      up_r <= up_set & ~pd_both; // RULE12
      dn_r <= dn_set & ~pd_both; // RULE12
      if (!pd_act)
        err_w_r <= {`ERR_W{1'b0}};
      else if (err_w_r != `ERR_MAX)
        err_w_r <= err_w_r + {{(`ERR_W-1){1'b0}}, 1'b1};
    end
  end

  // One-shot fast lock after start-up
  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      fl_on_r   <= 1'b0;
      fl_done_r <= 1'b0;
    end
    else if (!fl_done_r)
    begin
      if (run && locked_evt)
      begin
        fl_on_r   <= 1'b0;
        fl_done_r <= 1'b1; // RULE14
      end
      else
        fl_on_r <= run;
    end
    else
      fl_on_r <= 1'b0; // RULE14
  end

  // Output selection with test modes
  reg ld_nxt;
  reg fl_nxt;

  always @*
  begin
    ld_nxt = lock_en_r & run & ~pd_act; // RULE13
    fl_nxt = fl_on_r;
    if (tpin)
    begin
      if (!test_bit_r)
      begin
        ld_nxt = fn_tgl_r; // RULE11
        fl_nxt = 1'b1;
      end
      else
        ld_nxt = fr_tgl_r; // RULE11
    end
    if (!lock_en_r)
      ld_nxt = 1'b0; // RULE8
  end

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      lock_detect_out       <= 1'b0;
      fast_lock_out         <= 1'b0;
      charge_pump_up_out    <= 1'b0;
      charge_pump_dn_out    <= 1'b0;
      charge_pump_boost_out <= 1'b0;
    end
    else
    begin
      lock_detect_out       <= ld_nxt;
      fast_lock_out         <= fl_nxt;
      charge_pump_up_out    <= up_r;
      charge_pump_dn_out    <= dn_r;
      charge_pump_boost_out <= sync_r[I_FLC]; // RULE15
    end
  end

endmodule

//--- tb/pll_divider_programming_checker.sv
// Port checks for the PLL control block
// Assumes binding onto pll_divider_programming
`timescale 1ns/10ps
module pll_divider_programming_checker (
  // Clock, reset, pins
  input wire sys_clk_in,
  input wire nrst_in,
  input wire test_pin_in,
  input wire fast_lock_control_in,
  input wire battery_save_n_in,
  // Outputs watched
  input wire lock_detect_out,
  input wire fast_lock_out,
  input wire charge_pump_up_out,
  input wire charge_pump_dn_out,
  input wire charge_pump_boost_out
);
  reg [2:0] tp_low_r;
  reg       fl_done_r;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  always @(posedge sys_clk_in)
  begin
    if (!nrst_in || test_pin_in || !battery_save_n_in)
      tp_low_r <= 3'h0;
    else if (tp_low_r != 3'h7)
      tp_low_r <= tp_low_r + 3'h1;
    if (!nrst_in)
      fl_done_r <= 1'b0;
    else if (tp_low_r == 3'h7 && $fell(fast_lock_out))
      fl_done_r <= 1'b1;
  end
  a_reset_quiet: assert property ($rose(nrst_in) |-> !(lock_detect_out | fast_lock_out
    | charge_pump_up_out | charge_pump_dn_out | charge_pump_boost_out)) else $error("outputs not quiet");
  a_boost_rise: assert property ($rose(fast_lock_control_in) |-> ##[1:5] charge_pump_boost_out)
    else $error("boost late");
  a_boost_high: assert property (fast_lock_control_in [*5] |-> charge_pump_boost_out)
    else $error("boost low");
  a_boost_low: assert property (!fast_lock_control_in [*5] |-> !charge_pump_boost_out)
    else $error("boost high");
  a_pd_exclusive: assert property (!(charge_pump_up_out && charge_pump_dn_out))
    else $error("up and down together");
  a_ld_on_err: assert property (!test_pin_in [*5] ##0 (charge_pump_up_out || charge_pump_dn_out)
    |-> !lock_detect_out) else $error("lock high in error");
  a_standby_idle: assert property (!battery_save_n_in [*6]
    |-> !(charge_pump_up_out | charge_pump_dn_out | lock_detect_out)) else $error("active in standby");
  a_fl_once: assert property (fl_done_r && tp_low_r == 3'h7 |-> !fast_lock_out)
    else $error("fast lock again");
  cover property ($rose(charge_pump_up_out));
  cover property ($fell(fast_lock_out));
  cover property ($rose(charge_pump_boost_out));
endmodule

bind pll_divider_programming pll_divider_programming_checker chk_u (
  .sys_clk_in           (sys_clk_in),
  .nrst_in              (nrst_in),
  .test_pin_in          (test_pin_in),
  .fast_lock_control_in (fast_lock_control_in),
  .battery_save_n_in    (battery_save_n_in),
  .lock_detect_out      (lock_detect_out),
  .fast_lock_out        (fast_lock_out),
  .charge_pump_up_out   (charge_pump_up_out),
  .charge_pump_dn_out   (charge_pump_dn_out),
  .charge_pump_boost_out(charge_pump_boost_out)
);

//--- tb/pll_host_model.sv
// Host model shifting 19-bit words into the PLL block
// Assumes the bench supplies the 20 MHz clock and calls send_word
`timescale 1ns/10ps
module pll_host_model (
  // Clock
  input  wire sys_clk_in,
  // Serial lines
  output reg  ser_data_out,
  output reg  ser_clk_out,
  output reg  ser_en_out
);
  integer i;
  initial
  begin
    ser_data_out = 1'b0;
    ser_clk_out  = 1'b0;
    ser_en_out   = 1'b0;
  end
  task half;
  begin
    repeat (4) @(posedge sys_clk_in);
    #1;
  end
  endtask
  // Bit 18 first, selector last; link clock idles low
  task send_word(input [18:0] w);
  begin
    for (i = 18; i >= 0; i = i - 1)
    begin
      ser_data_out = w[i];
      half;
      ser_clk_out = 1'b1;
      half;
      ser_clk_out = 1'b0;
    end
    ser_en_out = 1'b1;
    half;
    ser_en_out = 1'b0;
    ser_data_out = ~w[0];
    half;
  end
  endtask
endmodule

//--- tb/pll_divider_programming_tb_top.sv
// Bench for the PLL control block
// Assumes the host model and the bound checker
`timescale 1ns/10ps
module pll_divider_programming_tb_top;
  reg     clk, nrst, wsel, tpin, fast_lock_control, bsn, fin, rin, run, ph, ldp;
  wire    sd, sc, se, ld, fl, up, dn, bst;
  integer err_total, samples_checked, ecnt, nmk, mk, mkp, c0, seen;
  pll_divider_programming dut_u (
    .sys_clk_in             (clk),
    .nrst_in                (nrst),
    .ser_data_in            (sd),
    .ser_clk_in             (sc),
    .ser_en_in              (se),
    .divider_width_select_in(wsel),
    .test_pin_in            (tpin),
    .fast_lock_control_in   (fast_lock_control),
    .battery_save_n_in      (bsn),
    .fin_in                 (fin),
    .ref_in                 (rin),
    .lock_detect_out        (ld),
    .fast_lock_out          (fl),
    .charge_pump_up_out     (up),
    .charge_pump_dn_out     (dn),
    .charge_pump_boost_out  (bst)
  );
  pll_host_model host_u (
    .sys_clk_in  (clk),
    .ser_data_out(sd),
    .ser_clk_out (sc),
    .ser_en_out  (se)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Divider inputs and lock output edge marks
  always @(posedge clk)
  begin
    #1;
    ph = ~ph;
    if (run && ph)
    begin
      fin = ~fin;
      rin = fin;
      ecnt = ecnt + fin;
    end
    if (ld !== ldp)
    begin
      ldp = ld;
      mkp = mk;
      mk = ecnt;
      nmk = nmk + 1;
    end
  end
  function [18:0] rw(input [14:0] rd, input en, input byp, input tb);
    rw = {rd, en, byp, tb, 1'b1};
  endfunction
  task end_sim;
  begin
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task step(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  // Input edges between two lock output toggles
  task period(input [31:0] exp);
    integer m0;
  begin
    m0 = nmk;
    c0 = 0;
    while (nmk < m0 + 3 && c0 < 3000)
    begin
      step(1);
      c0 = c0 + 1;
    end
    chk(c0 < 3000, 1);
    chk(mk - mkp, exp);
  end
  endtask
  initial
  begin
    #2000000;
    err_total = err_total + 1;
    end_sim;
  end
  initial
  begin
    {nrst, tpin, fast_lock_control, fin, rin, run, ph, ldp} = 8'h00;
    {wsel, bsn} = 2'h3;
    {err_total, samples_checked, ecnt, nmk, mk, mkp, seen} = 0;
    step(20);
    nrst = 1'b1;
    step(3);
    chk({ld, fl, up, dn}, 4'h0);
    host_u.send_word({18'h10062, 1'b0});
    host_u.send_word(rw(15'h0005, 1'b0, 1'b1, 1'b0));
    run = 1'b1;
    c0 = 0;
    repeat (400)
    begin
      step(1);
      if (ld !== 1'b0)
        c0 = 1;
      if (up === 1'b1)
        seen = 1;
    end
    chk(c0, 0);
    chk(seen, 1);
    chk(fl, 1);
    $display("lock disable test done");
    tpin = 1'b1;
    host_u.send_word(rw(15'h0005, 1'b1, 1'b1, 1'b0));
    period(98);
    chk(fl, 1);
    // Full-width N: upper bits make the feedback period very long
    wsel = 1'b0;
    step(1000);
    c0 = nmk;
    step(1500);
    chk(nmk - c0, 0);
    wsel = 1'b1;
    host_u.send_word(rw(15'h0005, 1'b1, 1'b1, 1'b1));
    period(5);
    host_u.send_word(rw(15'h0005, 1'b1, 1'b0, 1'b1));
    period(40);
    $display("divider ratio test done");
    tpin = 1'b0;
    host_u.send_word({18'h00020, 1'b0});
    host_u.send_word(rw(15'h0020, 1'b1, 1'b1, 1'b0));
    bsn = 1'b0;
    step(10);
    chk({up, dn, ld}, 3'h0);
    bsn = 1'b1;
    step(1500);
    chk(fl, 0);
    chk(ld, 1);
    host_u.send_word({18'h00062, 1'b0});
    step(1500);
    chk(fl, 0);
    // Feedback faster than reference: down pulses expected
    host_u.send_word({18'h00020, 1'b0});
    host_u.send_word(rw(15'h0040, 1'b1, 1'b1, 1'b0));
    seen = 0;
    repeat (600)
    begin
      step(1);
      if (dn === 1'b1)
        seen = 1;
    end
    chk(seen, 1);
    $display("fast lock test done");
    fast_lock_control = 1'b1;
    step(8);
    chk(bst, 1);
    fast_lock_control = 1'b0;
    step(8);
    chk(bst, 0);
    $display("boost test done");
    end_sim;
  end
endmodule
